/* File: src/pct_pkg.sv */
package pct_pkg;

    // register byte addresses
    localparam logic [7:0] A_CNT_LO  = 8'h00;
    localparam logic [7:0] A_CNT_HI  = 8'h04;
    localparam logic [7:0] A_MODE    = 8'h08;
    localparam logic [7:0] A_STAT    = 8'h0c;
    localparam logic [7:0] A_CLR     = 8'h10;
    localparam logic [7:0] A_IEN     = 8'h14;
    localparam logic [7:0] A_CHCTL   = 8'h18;
    localparam logic [7:0] A_CMP0    = 8'h20;
    localparam logic [7:0] A_CMP_END = 8'h38;

    localparam int NCH      = 6;
    localparam int WDT_CH   = 5;
    localparam int NSTAT    = 8;

    // mode register fields
    localparam int M_SEL    = 1;
    localparam int M_WDT    = 6;
    localparam int M_IDLE   = 7;
    localparam int M_CLEN   = 8;

    // status, clear and enable layout
    localparam int S_CF     = 0;
    localparam int S_PCF    = 1;
    localparam int S_CH0    = 2;

    // channel control fields
    localparam int C_IOEN   = 0;
    localparam int C_CMPEN  = 8;

    // prescaler figures
    localparam int DIV_SLOW = 12;
    localparam int DIV_FAST = 4;
    localparam int DIV_XOSC = 8;
    localparam logic [3:0] PRE_LAST  = 4'(DIV_SLOW - 1);
    localparam logic [1:0] FAST_LAST = 2'(DIV_FAST - 1);
    localparam logic [2:0] XOSC_LAST = 3'(DIV_XOSC - 1);
    localparam logic [15:0] CNT_MAX  = 16'hffff;

    typedef enum logic [2:0] {
        SRC_DIV12 = 3'b000,
        SRC_DIV4  = 3'b001,
        SRC_T0    = 3'b010,
        SRC_ECI   = 3'b011,
        SRC_SYS   = 3'b100,
        SRC_XOSC  = 3'b101,
        SRC_RSV6  = 3'b110,
        SRC_RSV7  = 3'b111
    } pct_src_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } pct_av_req_s;

endpackage

/* File: src/pct_edge_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module pct_edge_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    // asynchronous pin
    input  wire logic din,
    // edge pulses
    output logic      rise,
    output logic      fall
);

    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else if (ce) begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    assign rise = s2 & ~s3;
    assign fall = ~s2 & s3;

endmodule // pct_edge_sync

`default_nettype wire

/* File: src/pct_timebase.sv */
// How it works
// - sixteen-bit up-counter read by software as separate low and high bytes.
// - low-byte read latches high byte; next high-byte read returns that copy.
// - reading counter bytes never stalls, skips or resets counting.
// - three-bit select: sysclk/12, sysclk/4, timer-0 overflow, sysclk; 11x reserved.
// - code 011 counts falling edges of external input, up to sysclk/2.
// - code 101 counts external oscillator divided by 8, resynchronised first.
// - wrap from all ones to zero sets the overflow flag.
// - overflow raises interrupt only while its enable bit is one.
// - overflow flag stays set until software clears it.
// - idle-suspend bit zero keeps counting in idle; one halts it.
// - six 16-bit compare channels on the shared counter, each with I/O line.
// - channel 5 is watchdog after reset; mode writes restricted meanwhile.
// - partial flag set on carry into bit 8 to 11 per length setting.
`timescale 1ns/10ps
`default_nettype none

module pct_timebase (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    // register bus
    input  wire pct_pkg::pct_av_req_s av,
    output logic                      av_waitrequest,
    output logic [31:0]               av_readdata,
    // count sources and core state
    input  wire logic                 cpu_idle,
    input  wire logic                 t0_ovf,
    input  wire logic                 ext_count_input,
    input  wire logic                 ext_osc,
    // channel lines
    output logic [5:0]                channel_io_line,
    output logic [5:0]                channel_io_oe_n,
    // system outputs
    output logic                      watchdog_reset,
    output logic                      irq
);

    logic              ack;
    logic              req;
    logic              acc;
    logic              first;
    logic [15:0]       counter_array;
    logic [15:0]       next_count;
    logic [7:0]        snap;
    pct_pkg::pct_src_e timebase_select;
    logic              watchdog_channel;
    logic              idle_suspend;
    logic [1:0]        clen;
    logic [3:0]        pre;
    logic [2:0]        xdiv;
    logic [7:0]        status;
    logic [7:0]        ien;
    logic [7:0]        ev;
    logic [7:0]        clr;
    logic [5:0]        io_en;
    logic [5:0]        cmp_en;
    logic [15:0]       cmp [pct_pkg::NCH];
    logic [5:0]        match;
    logic [7:0]        cidx;
    logic              cmp_hit;
    logic              eci_fall;
    logic              xosc_rise;
    logic              xosc_tick;
    logic              active;
    logic              tick_src;
    logic              tick;
    logic              partial;
    logic [31:0]       next_rdata;

    // bus handshake: one wait cycle per access
    assign req            = av.read | av.write;
    assign av_waitrequest = req & ~ack;
    assign acc            = req & ack;
    assign first          = req & ~ack;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
        end else if (ce) begin
            ack <= first;
        end
    end

    assign cmp_hit = (av.address >= pct_pkg::A_CMP0) && (av.address < pct_pkg::A_CMP_END)
                     && (av.address[1:0] == 2'h0);
    assign cidx    = (av.address - pct_pkg::A_CMP0) >> 2;

    always_comb begin
        next_rdata = 32'h0;
        if (cmp_hit) begin
            next_rdata = {16'h0, cmp[cidx[2:0]]};
        end else begin
            case (av.address)
                pct_pkg::A_CNT_LO: next_rdata = {24'h0, counter_array[7:0]};
                pct_pkg::A_CNT_HI: next_rdata = {24'h0, snap};
                pct_pkg::A_MODE:   next_rdata = {22'h0, clen, idle_suspend, watchdog_channel,
                                                 2'h0, timebase_select, 1'b0};
                pct_pkg::A_STAT:   next_rdata = {24'h0, status};
                pct_pkg::A_IEN:    next_rdata = {24'h0, ien};
                pct_pkg::A_CHCTL:  next_rdata = {18'h0, cmp_en, 2'h0, io_en};
                default:           next_rdata = 32'h0;
            endcase
        end
    end

    // read data and snapshot taken on the same edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            av_readdata <= 32'h0;
        end else if (ce && first && av.read) begin
            av_readdata <= next_rdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            snap <= 8'h0;
        end else if (ce && first && av.read && av.address == pct_pkg::A_CNT_LO) begin
            snap <= counter_array[15:8];
        end
    end

    // mode register; watchdog blocks all but clearing its own bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timebase_select  <= pct_pkg::SRC_DIV12;
            watchdog_channel <= 1'b1;
            idle_suspend     <= 1'b0;
            clen             <= 2'h0;
        end else if (ce && acc && av.write && av.address == pct_pkg::A_MODE) begin
            watchdog_channel <= av.writedata[pct_pkg::M_WDT];
            if (!watchdog_channel) begin
                timebase_select <= pct_pkg::pct_src_e'(av.writedata[pct_pkg::M_SEL +: 3]);
                idle_suspend    <= av.writedata[pct_pkg::M_IDLE];
                clen            <= av.writedata[pct_pkg::M_CLEN +: 2];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ien <= 8'h0;
        end else if (ce && acc && av.write && av.address == pct_pkg::A_IEN) begin
            ien <= av.writedata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            io_en  <= 6'h0;
            cmp_en <= 6'h0;
        end else if (ce && acc && av.write && av.address == pct_pkg::A_CHCTL) begin
            io_en  <= av.writedata[pct_pkg::C_IOEN +: 6];
            cmp_en <= av.writedata[pct_pkg::C_CMPEN +: 6];
        end
    end

    // count sources
    pct_edge_sync u_eci (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .din  (ext_count_input),
        .rise (),
        .fall (eci_fall)
    );

    pct_edge_sync u_xosc (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .din  (ext_osc),
        .rise (xosc_rise),
        .fall ()
    );

    assign active = ~(idle_suspend & cpu_idle);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre <= 4'h0;
        end else if (ce && active) begin
            pre <= (pre == pct_pkg::PRE_LAST) ? 4'h0 : pre + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xdiv <= 3'h0;
        end else if (ce && xosc_rise) begin
            xdiv <= xdiv + 3'h1;
        end
    end

    assign xosc_tick = xosc_rise & (xdiv == pct_pkg::XOSC_LAST);

    always_comb begin
        tick_src = 1'b0;
        case (timebase_select)
            pct_pkg::SRC_DIV12: tick_src = (pre == pct_pkg::PRE_LAST);
            pct_pkg::SRC_DIV4:  tick_src = (pre[1:0] == pct_pkg::FAST_LAST);
            pct_pkg::SRC_T0:    tick_src = t0_ovf;
            pct_pkg::SRC_ECI:   tick_src = eci_fall;
            pct_pkg::SRC_SYS:   tick_src = 1'b1;
            pct_pkg::SRC_XOSC:  tick_src = xosc_tick;
            default:            tick_src = 1'b0;
        endcase
    end

    assign tick       = tick_src & active;
    assign next_count = counter_array + 16'h1;

    // bus reads never touch the counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            counter_array <= 16'h0;
        end else if (ce && tick) begin
            counter_array <= next_count;
        end
    end

    always_comb begin
        partial = 1'b0;
        case (clen)
            2'h0: partial = &counter_array[7:0];
            2'h1: partial = &counter_array[8:0];
            2'h2: partial = &counter_array[9:0];
            2'h3: partial = &counter_array[10:0];
        endcase
    end

    // compare channels
    genvar gi;
    generate
        for (gi = 0; gi < pct_pkg::NCH; gi++) begin : g_ch
            logic wdt_arm;
            assign wdt_arm   = (gi == pct_pkg::WDT_CH) && watchdog_channel;
            assign match[gi] = tick && (cmp_en[gi] || wdt_arm) && next_count == cmp[gi];

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    cmp[gi] <= 16'h0;
                end else if (ce && acc && av.write && cmp_hit && cidx == 8'(gi)) begin
                    cmp[gi] <= av.writedata[15:0];
                end
            end

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    channel_io_line[gi] <= 1'b0;
                end else if (ce && match[gi]) begin
                    channel_io_line[gi] <= ~channel_io_line[gi];
                end
            end
        end
    endgenerate

    assign channel_io_oe_n = ~io_en;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            watchdog_reset <= 1'b0;
        end else if (ce) begin
            watchdog_reset <= match[pct_pkg::WDT_CH] & watchdog_channel;
        end
    end

    // sticky events, set wins over clear
    assign ev[pct_pkg::S_CF]       = tick & (counter_array == pct_pkg::CNT_MAX);
    assign ev[pct_pkg::S_PCF]      = tick & partial;
    assign ev[pct_pkg::S_CH0 +: 6] = match;
    assign clr = (acc && av.write && av.address == pct_pkg::A_CLR) ? av.writedata[7:0] : 8'h0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status <= 8'h0;
        end else if (ce) begin
            status <= (status & ~clr) | ev;
        end
    end

    assign irq = |(status & ien);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_wrap;
        ce && tick && counter_array == pct_pkg::CNT_MAX |=> counter_array == 16'h0 && status[0];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap did not set overflow flag");

    property p_irq_gate;
        !ien[0] && status[7:1] == 7'h0 |-> !irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("overflow irq while disabled");

    property p_irq_on;
        status[0] && ien[0] |-> irq;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("enabled overflow gave no irq");

    property p_sticky;
        status[0] && !clr[0] |=> status[0];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("overflow flag lost");

    property p_snap;
        ce && first && av.read && av.address == pct_pkg::A_CNT_LO |=> snap == $past(counter_array[15:8]);
    endproperty
    a_snap: assert property (p_snap)
        else $error("snapshot not latched");

    property p_read_count;
        ce && tick && av.read |=> counter_array == $past(counter_array) + 16'h1;
    endproperty
    a_read_count: assert property (p_read_count)
        else $error("read disturbed counting");

    property p_sys;
        timebase_select == pct_pkg::SRC_SYS && active |-> tick;
    endproperty
    a_sys: assert property (p_sys)
        else $error("system clock source not counting");

    property p_div4;
        ce && timebase_select == pct_pkg::SRC_DIV4 && tick
        |=> (!tick || timebase_select != pct_pkg::SRC_DIV4) [*3];
    endproperty
    a_div4: assert property (p_div4)
        else $error("divide by four too fast");

    property p_eci;
        timebase_select == pct_pkg::SRC_ECI && active && eci_fall |-> tick;
    endproperty
    a_eci: assert property (p_eci)
        else $error("external edge not counted");

    property p_idle;
        idle_suspend && cpu_idle |=> $stable(counter_array);
    endproperty
    a_idle: assert property (p_idle)
        else $error("counter moved in suspended idle");

    property p_partial;
        ce && tick && partial |=> status[1];
    endproperty
    a_partial: assert property (p_partial)
        else $error("partial overflow flag missed");

    property p_wdt;
        ce && match[5] && watchdog_channel |=> watchdog_reset;
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog match gave no reset");

    property p_wdt_lock;
        watchdog_channel && ce && acc && av.write && av.address == pct_pkg::A_MODE |=> $stable(timebase_select);
    endproperty
    a_wdt_lock: assert property (p_wdt_lock)
        else $error("mode changed under watchdog");

    property p_match_io;
        ce && match[0] |=> channel_io_line[0] != $past(channel_io_line[0]) && status[2];
    endproperty
    a_match_io: assert property (p_match_io)
        else $error("channel match not seen");

endmodule // pct_timebase

`default_nettype wire

/* File: tb/pct_far_model.sv */
`timescale 1ns/10ps
`default_nettype none

module pct_far_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // far-side sources
    output logic      ext_count_input,
    output logic      ext_osc,
    output logic      t0_ovf
);
    // one shared 24-step cycle keeps every source periodic within it
    logic [4:0] step;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            step <= 5'h00;
        end else begin
            step <= (step == 5'h17) ? 5'h00 : step + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            t0_ovf <= 1'b0;
        end else begin
            t0_ovf <= (step % 5'h06) == 5'h00;
        end
    end

    assign ext_count_input = step[2];
    assign ext_osc         = step[1];
endmodule // pct_far_model

`default_nettype wire

/* File: tb/tb_prog_counter_timebase.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_prog_counter_timebase;
    logic                 clk;
    logic                 rstn;
    logic                 cpu_idle;
    pct_pkg::pct_av_req_s av;
    logic                 av_waitrequest;
    logic [31:0]          av_readdata;
    logic                 t0_ovf;
    logic                 ext_count_input;
    logic                 ext_osc;
    logic [5:0]           channel_io_line;
    logic [5:0]           channel_io_oe_n;
    logic                 watchdog_reset;
    logic                 irq;
    logic                 wdt_seen;
    int                   n_errors;
    int                   num_checks;
    int                   cycles;
    logic [31:0]          d;
    logic [31:0]          h;
    logic [15:0]          v;
    logic [7:0]           exp_t [8] = '{8'h08, 8'h18, 8'h10, 8'h0c, 8'h60, 8'h03, 8'h00, 8'h00};

    pct_timebase uut (
        .clk             (clk),
        .rstn            (rstn),
        .ce              (1'b1),
        .av              (av),
        .av_waitrequest  (av_waitrequest),
        .av_readdata     (av_readdata),
        .cpu_idle        (cpu_idle),
        .t0_ovf          (t0_ovf),
        .ext_count_input (ext_count_input),
        .ext_osc         (ext_osc),
        .channel_io_line (channel_io_line),
        .channel_io_oe_n (channel_io_oe_n),
        .watchdog_reset  (watchdog_reset),
        .irq             (irq)
    );

    pct_far_model far (
        .clk             (clk),
        .rstn            (rstn),
        .ext_count_input (ext_count_input),
        .ext_osc         (ext_osc),
        .t0_ovf          (t0_ovf)
    );

    always #5 clk = ~clk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog reset is a one-cycle pulse: keep a sticky copy
    always @(posedge clk) begin
        if (watchdog_reset === 1'b1) begin
            wdt_seen <= 1'b1;
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // request held until waitrequest is seen low, then released for one edge
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        av.read    <= 1'b1;
        av.address <= a;
        do @(posedge clk); while (av_waitrequest !== 1'b0);
        q = av_readdata;
        av.read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        av.write     <= 1'b1;
        av.address   <= a;
        av.writedata <= w;
        do @(posedge clk); while (av_waitrequest !== 1'b0);
        av.write <= 1'b0;
        @(posedge clk);
    endtask

    // counts seen over 96 clocks between two low-byte samples
    task automatic span(input logic [31:0] mode, input logic [7:0] e);
        logic [31:0] a;
        logic [31:0] b;
        wr(pct_pkg::A_MODE, mode);
        repeat (8) @(posedge clk);
        rd(pct_pkg::A_CNT_LO, a);
        repeat (93) @(posedge clk);
        rd(pct_pkg::A_CNT_LO, b);
        chk("count span", {24'h0, e}, {24'h0, b[7:0] - a[7:0]});
    endtask

    initial begin
        clk        = 1'b0;
        rstn       = 1'b0;
        cpu_idle   = 1'b0;
        av         = '0;
        n_errors   = 0;
        num_checks = 0;
        cycles     = 0;
        wdt_seen   = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);

        rd(pct_pkg::A_MODE, d);
        chk("mode reset", 32'h00000040, d);
        chk("oe reset", 32'h0000003f, {26'h0, channel_io_oe_n});
        wr(pct_pkg::A_MODE, 32'h000000ca);
        rd(pct_pkg::A_MODE, d);
        chk("mode locked", 32'h00000040, d);
        chk("watchdog idle", 32'h0, {31'h0, wdt_seen});
        rd(pct_pkg::A_CNT_LO, d);
        rd(pct_pkg::A_CNT_HI, h);
        wr(pct_pkg::A_CMP0 + 8'h14, {16'h0, h[7:0], d[7:0]} + 32'd4);
        repeat (70) @(posedge clk);
        chk("watchdog pulse", 32'h1, {31'h0, wdt_seen});
        // leaving watchdog mode drops the other fields of that write
        wr(pct_pkg::A_MODE, 32'h00000008);
        rd(pct_pkg::A_MODE, d);
        chk("mode unlock", 32'h00000000, d);
        wr(pct_pkg::A_MODE, 32'h00000008);
        rd(pct_pkg::A_MODE, d);
        chk("mode free", 32'h00000008, d);
        rd(8'h3c, d);
        chk("unmapped", 32'h0, d);
        $display("done reset and mode");

        rd(pct_pkg::A_CNT_LO, d);
        rd(pct_pkg::A_CNT_HI, h);
        v = {h[7:0], d[7:0]};
        rd(pct_pkg::A_CNT_LO, d);
        repeat (300) @(posedge clk);
        rd(pct_pkg::A_CNT_HI, h);
        chk("snapshot", {16'h0, v + 16'h0006}, {16'h0, h[7:0], d[7:0]});
        $display("done snapshot");

        wr(pct_pkg::A_CHCTL, 32'h0000013f);
        chk("oe on", 32'h0, {26'h0, channel_io_oe_n});
        rd(pct_pkg::A_CNT_LO, d);
        rd(pct_pkg::A_CNT_HI, h);
        wr(pct_pkg::A_CMP0, {16'h0, h[7:0], d[7:0]} + 32'd40);
        repeat (60) @(posedge clk);
        rd(pct_pkg::A_STAT, d);
        chk("match flag", 32'h1, {31'h0, d[2]});
        chk("io toggle", 32'h1, {31'h0, channel_io_line[0]});
        $display("done channel");

        wr(pct_pkg::A_CLR, 32'h000000ff);
        d = '0;
        while (d[0] !== 1'b1) rd(pct_pkg::A_STAT, d);
        chk("partial flag", 32'h1, {31'h0, d[1]});
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(pct_pkg::A_CNT_LO, d);
        chk("wrap low", 32'h1, {31'h0, d[7:0] < 8'h08});
        wr(pct_pkg::A_IEN, 32'h00000001);
        chk("irq on", 32'h1, {31'h0, irq});
        rd(pct_pkg::A_STAT, d);
        chk("flag held", 32'h1, {31'h0, d[0]});
        wr(pct_pkg::A_CLR, 32'h000000ff);
        rd(pct_pkg::A_STAT, d);
        chk("flag clear", 32'h0, {31'h0, d[0]});
        chk("irq off", 32'h0, {31'h0, irq});
        $display("done overflow");

        for (int c = 0; c < 8; c++) begin
            span(32'(c) << 1, exp_t[c]);
        end
        cpu_idle <= 1'b1;
        span(32'h00000008, 8'h60);
        span(32'h00000088, 8'h00);
        cpu_idle <= 1'b0;
        $display("done sources and idle");
        end_sim();
    end
endmodule // tb_prog_counter_timebase

`default_nettype wire
